// ---- src/fur_pkg.sv ----
// Shared constants and types for the receive status and baud block
package fur_pkg;
  // ==========================================================
  // Bus and data widths
  localparam int FUR_ADR_W = 8;
  localparam int FUR_DAT_W = 32;
  localparam int FUR_CHAR_W = 8;
  localparam int FUR_CNT_W = 5;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] FUR_OFF_MODE = 8'h00;
  localparam logic [7:0] FUR_OFF_BRR = 8'h04;
  localparam logic [7:0] FUR_OFF_STATUS = 8'h08;
  localparam logic [7:0] FUR_OFF_FCR = 8'h0c;
  localparam logic [7:0] FUR_OFF_RXDATA = 8'h10;
  localparam logic [7:0] FUR_OFF_FCOUNT = 8'h14;
  localparam logic [7:0] FUR_OFF_IRQ_STS = 8'h18;
  localparam logic [7:0] FUR_OFF_IRQ_MASK = 8'h1c;
  // ==========================================================
  // Field positions
  localparam int FUR_MODE_CKS_LO = 0;
  localparam int FUR_MODE_ODD = 4;
  localparam int FUR_MODE_PAR_EN = 5;
  localparam int FUR_FCR_TRG_LO = 6;
  localparam int FUR_ST_DR = 0;
  localparam int FUR_ST_RDF = 1;
  localparam int FUR_ST_PER = 2;
  localparam int FUR_ST_FER = 3;
  localparam int FUR_ST_BRK = 4;
  localparam int FUR_ST_FCNT_LO = 8;
  localparam int FUR_ST_PCNT_LO = 12;
  localparam int FUR_IRQ_W = 4;
  // ==========================================================
  // Reset values
  localparam logic [7:0] FUR_BRR_RST = 8'hff;
  localparam logic [7:0] FUR_MODE_RST = 8'h00;
  localparam logic [7:0] FUR_FCR_RST = 8'h00;
  localparam logic [3:0] FUR_MASK_RST = 4'h0;
  // ==========================================================
  // Timing counts
  localparam int FUR_TICKS_PER_BIT = 32;
  localparam int FUR_TIMEOUT_ETU = 15;
  localparam int FUR_TIMEOUT_TICKS = FUR_TIMEOUT_ETU * FUR_TICKS_PER_BIT;
  localparam int FUR_FIFO_DEPTH = 16;
  // ==========================================================
  // Types
  typedef struct packed {
    logic perr;
    logic ferr;
    logic [FUR_CHAR_W-1:0] data;
  } fur_rx_entry_type;

  typedef enum logic [2:0] {
    FUR_IDLE = 3'b000,
    FUR_START = 3'b001,
    FUR_DATA = 3'b011,
    FUR_PARITY = 3'b010,
    FUR_STOP = 3'b110
  } fur_rx_state_type;

  // Trigger count from the two trigger-select bits
  function automatic logic [FUR_CNT_W-1:0] fur_trig(input logic [1:0] sel);
    case (sel)
      2'b00: fur_trig = 5'h01;
      2'b01: fur_trig = 5'h04;
      2'b10: fur_trig = 5'h08;
      default: fur_trig = 5'h0e;
    endcase
  endfunction
endpackage

// ---- src/fur_baud_gen.sv ----
// Baud tick generator: prescaled clock and 8-bit divider
`timescale 1ns/100ps
`default_nettype none
module fur_baud_gen (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_clr,
  // Settings
  input wire logic [1:0] i_cks,
  input wire logic [7:0] i_divn,
  // Tick, 32 per bit period
  output logic o_tick
);
  import fur_pkg::*;

  logic [5:0] pre_cnt_reg;
  logic [7:0] div_cnt_reg;
  logic [5:0] pre_last;
  logic pre_wrap;

  // ==========================================================
  // Prescaler of 1, 4, 16 or 64
  always_comb begin
    case (i_cks)
      2'b00: pre_last = 6'h00;
      2'b01: pre_last = 6'h03;
      2'b10: pre_last = 6'h0f;
      default: pre_last = 6'h3f;
    endcase
  end
  assign pre_wrap = (pre_cnt_reg >= pre_last);

  always_ff @(posedge i_clk_sys) begin
    if (i_clr || pre_wrap) begin
      pre_cnt_reg <= 6'h00; // [R16]
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 6'h01;
    end
  end

  // ==========================================================
  // Divide by N+1, giving a bit of 32*4^n*(N+1) clocks
  always_ff @(posedge i_clk_sys) begin
    if (i_clr) begin
      div_cnt_reg <= 8'h00;
      o_tick <= 1'b0;
    end else begin
      o_tick <= 1'b0;
      if (pre_wrap) begin
        if (div_cnt_reg >= i_divn) begin
          div_cnt_reg <= 8'h00; // [R15]
          o_tick <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // Checks
  property p_tick_div2;
    @(posedge i_clk_sys) disable iff (i_clr)
    (o_tick && i_cks == 2'b00 && i_divn == 8'h01 && $stable(i_divn)) |=> !o_tick;
  endproperty
  a_tick_div2: assert property (p_tick_div2) else $error("Tick too early for divider 1"); // [R15]

  property p_pre_bound;
    @(posedge i_clk_sys) disable iff (i_clr)
    (i_cks == 2'b01 && $stable(i_cks)) |-> pre_cnt_reg <= 6'h03;
  endproperty
  a_pre_bound: assert property (p_pre_bound) else $error("Prescaler past divide by 4"); // [R16]
endmodule
`default_nettype wire

// ---- src/fur_uart_rx.sv ----
// Receive status, receive FIFO and bit-rate registers over Wishbone
// Function
// R1: After a break frame is stored, store nothing until mark returns and a new char.
// R2: Framing error flag set when the byte read from the FIFO has a framing error.
// R3: Framing error flag clears on reset, standby, or a clean read byte.
// R4: Parity error flag set when the byte read from the FIFO has a parity error.
// R5: Parity error flag clears on reset, standby, or a read byte without parity error.
// R6: Fill flag sets when FIFO count reaches the selected trigger count.
// R7: Fill flag clears on reset, standby, count below trigger, or write 0 after read 1.
// R8: FIFO holds 16 bytes; a read while empty gives undefined data.
// R9: FIFO count register low byte gives bytes held in the receive FIFO.
// R10: Ready flag sets when below trigger and no character starts 15 etu after stop.
// R11: Ready flag clears on reset, standby, or write 0 only after reading 1.
// R12: Status bits 15 to 12 count stored bytes with parity error.
// R13: Status bits 11 to 8 count stored bytes with framing error.
// R14: Bit-rate register is read/write and loads all ones on reset and standby.
// R15: Bit period follows N = Pclk/(64*2^(2n-1)*B) - 1, N from 0 to 255.
// R16: Clock-select bits pick the clock divided by 1, 4, 16 or 64.
// R17: Break flag sets on a framing-error character whose data is all space.
// R18: One etu of the timeout equals one bit period of the baud settings.
`timescale 1ns/100ps
`default_nettype none
module fur_uart_rx #(
  parameter int DEPTH = fur_pkg::FUR_FIFO_DEPTH
) (
  // Clock, reset and standby
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_standby,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [fur_pkg::FUR_ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [fur_pkg::FUR_DAT_W-1:0] i_wb_dat,
  output logic [fur_pkg::FUR_DAT_W-1:0] o_wb_dat,
  output logic o_wb_ack,
  // Serial receive line
  input wire logic i_rxd,
  // Interrupt
  output logic o_irq
);
  import fur_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic clr;
  logic take;
  logic wr;
  logic rd;
  logic [7:0] mode_reg;
  logic [7:0] brr_reg;
  logic [7:0] fcr_reg;
  logic [3:0] mask_reg;
  logic [3:0] irq_sts_reg;
  logic [2:0] rx_sync_reg;
  logic rx_line_reg;
  logic tick;
  fur_rx_state_type state_reg;
  logic [4:0] tick_cnt_reg;
  logic [2:0] bit_idx_reg;
  logic [7:0] shift_reg;
  logic par_acc_reg;
  logic par_bad_reg;
  logic done_reg;
  fur_rx_entry_type frame_reg;
  logic block_reg;
  fur_rx_entry_type mem_reg [DEPTH];
  logic [3:0] wr_ptr_reg;
  logic [3:0] rd_ptr_reg;
  logic [FUR_CNT_W-1:0] cnt_reg;
  logic [FUR_CNT_W-1:0] pcnt_reg;
  logic [FUR_CNT_W-1:0] fcnt_reg;
  fur_rx_entry_type head;
  logic push;
  logic pop;
  logic push_q_reg;
  logic [FUR_CNT_W-1:0] trig;
  logic at_trig;
  logic [8:0] tmo_cnt_reg;
  logic tmo_run_reg;
  logic tmo_evt;
  logic brk_evt;
  logic fer_reg;
  logic per_reg;
  logic rdf_reg;
  logic dr_reg;
  logic brk_reg;
  logic [2:0] arm_reg;
  logic sts_wr;
  logic sts_rd;
  logic [3:0] pcnt_show;
  logic [3:0] fcnt_show;
  logic [15:0] status;
  logic [31:0] rdata;

  assign clr = i_sys_rst | i_standby;
  assign take = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr = take & i_wb_we & i_wb_sel[0];
  assign rd = take & ~i_wb_we;
  assign sts_wr = wr & hit(i_wb_adr, FUR_OFF_STATUS);
  assign sts_rd = rd & hit(i_wb_adr, FUR_OFF_STATUS);

  // ==========================================================
  // Bus handshake and read data
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= take;
      o_wb_dat <= take ? rdata : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge i_clk_sys) begin
    if (clr) begin
      mode_reg <= FUR_MODE_RST;
      brr_reg <= FUR_BRR_RST; // [R14]
      fcr_reg <= FUR_FCR_RST;
      mask_reg <= FUR_MASK_RST;
    end else if (wr) begin
      if (hit(i_wb_adr, FUR_OFF_MODE)) begin
        mode_reg <= i_wb_dat[7:0];
      end else if (hit(i_wb_adr, FUR_OFF_BRR)) begin
        brr_reg <= i_wb_dat[7:0]; // [R14]
      end else if (hit(i_wb_adr, FUR_OFF_FCR)) begin
        fcr_reg <= i_wb_dat[7:0];
      end else if (hit(i_wb_adr, FUR_OFF_IRQ_MASK)) begin
        mask_reg <= i_wb_dat[3:0];
      end
    end
  end

  // ==========================================================
  // Baud ticks
  fur_baud_gen u_baud (
    .i_clk_sys(i_clk_sys),
    .i_clr(clr),
    .i_cks(mode_reg[FUR_MODE_CKS_LO+:2]), // [R16]
    .i_divn(brr_reg), // [R15]
    .o_tick(tick)
  );

  // ==========================================================
  // Receive line synchroniser
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rx_sync_reg <= 3'b111;
      rx_line_reg <= 1'b1;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], i_rxd};
      if (rx_sync_reg[1] == rx_sync_reg[2]) begin
        rx_line_reg <= rx_sync_reg[2];
      end
    end
  end

  // ==========================================================
  // Character receiver
  always_ff @(posedge i_clk_sys) begin
    if (clr) begin
      state_reg <= FUR_IDLE;
      tick_cnt_reg <= 5'h00;
      bit_idx_reg <= 3'h0;
      shift_reg <= 8'h00;
      par_acc_reg <= 1'b0;
      par_bad_reg <= 1'b0;
      done_reg <= 1'b0;
      frame_reg <= '0;
    end else begin
      done_reg <= 1'b0;
      if (tick) begin
        tick_cnt_reg <= tick_cnt_reg + 5'h01;
      end
      case (state_reg)
        FUR_IDLE: begin
          tick_cnt_reg <= 5'h00;
          if (!rx_line_reg) begin
            state_reg <= FUR_START;
          end
        end
        FUR_START: begin
          if (tick && tick_cnt_reg == 5'h0f) begin
            tick_cnt_reg <= 5'h00;
            bit_idx_reg <= 3'h0;
            par_acc_reg <= mode_reg[FUR_MODE_ODD];
            state_reg <= rx_line_reg ? FUR_IDLE : FUR_DATA;
          end
        end
        FUR_DATA: begin
          if (tick && tick_cnt_reg == 5'h1f) begin
            shift_reg <= {rx_line_reg, shift_reg[7:1]};
            par_acc_reg <= par_acc_reg ^ rx_line_reg;
            bit_idx_reg <= bit_idx_reg + 3'h1;
            if (bit_idx_reg == 3'h7) begin
              state_reg <= mode_reg[FUR_MODE_PAR_EN] ? FUR_PARITY : FUR_STOP;
              par_bad_reg <= 1'b0;
            end
          end
        end
        FUR_PARITY: begin
          if (tick && tick_cnt_reg == 5'h1f) begin
            par_bad_reg <= par_acc_reg ^ rx_line_reg;
            state_reg <= FUR_STOP;
          end
        end
        FUR_STOP: begin
          if (tick && tick_cnt_reg == 5'h1f) begin
            frame_reg <= '{perr: par_bad_reg, ferr: ~rx_line_reg, data: shift_reg};
            done_reg <= 1'b1;
            state_reg <= FUR_IDLE;
          end
        end
        default: state_reg <= FUR_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Break handling
  assign brk_evt = done_reg & frame_reg.ferr & (frame_reg.data == 8'h00); // [R17]

  always_ff @(posedge i_clk_sys) begin
    if (clr) begin
      block_reg <= 1'b0;
    end else if (brk_evt && !block_reg) begin
      block_reg <= 1'b1; // [R1]
    end else if (state_reg == FUR_IDLE && rx_line_reg) begin
      block_reg <= 1'b0; // [R1]
    end
  end

  // ==========================================================
  // Receive FIFO
  assign head = mem_reg[rd_ptr_reg];
  assign push = done_reg & ~block_reg & (cnt_reg < DEPTH[FUR_CNT_W-1:0]); // [R1] [R8]
  assign pop = rd & hit(i_wb_adr, FUR_OFF_RXDATA) & (cnt_reg != 5'h00);

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= frame_reg;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (clr) begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      cnt_reg <= 5'h00;
      pcnt_reg <= 5'h00;
      fcnt_reg <= 5'h00;
      push_q_reg <= 1'b0;
    end else begin
      push_q_reg <= push;
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 4'h1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 4'h1;
      end
      cnt_reg <= cnt_reg + {4'h0, push} - {4'h0, pop}; // [R9]
      pcnt_reg <= pcnt_reg + {4'h0, push & frame_reg.perr} - {4'h0, pop & head.perr}; // [R12]
      fcnt_reg <= fcnt_reg + {4'h0, push & frame_reg.ferr} - {4'h0, pop & head.ferr}; // [R13]
    end
  end

  // ==========================================================
  // Receive timeout
  assign trig = fur_trig(fcr_reg[FUR_FCR_TRG_LO+:2]);
  assign at_trig = (cnt_reg >= trig);
  assign tmo_evt = tmo_run_reg & tick & (tmo_cnt_reg == 9'(FUR_TIMEOUT_TICKS - 1));

  always_ff @(posedge i_clk_sys) begin
    if (clr) begin
      tmo_run_reg <= 1'b0;
      tmo_cnt_reg <= 9'h000;
    end else if (done_reg) begin
      tmo_run_reg <= 1'b1;
      tmo_cnt_reg <= 9'h000;
    end else if (state_reg != FUR_IDLE || tmo_evt) begin
      tmo_run_reg <= 1'b0;
    end else if (tick) begin
      tmo_cnt_reg <= tmo_cnt_reg + 9'h001; // [R18]
    end
  end

  // ==========================================================
  // Status flags
  always_ff @(posedge i_clk_sys) begin
    if (clr) begin
      fer_reg <= 1'b0; // [R3]
      per_reg <= 1'b0; // [R5]
    end else if (pop) begin
      fer_reg <= head.ferr; // [R2] [R3]
      per_reg <= head.perr; // [R4] [R5]
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (clr) begin
      rdf_reg <= 1'b0;
    end else if (at_trig && push_q_reg) begin
      rdf_reg <= 1'b1; // [R6]
    end else if (!at_trig) begin
      rdf_reg <= 1'b0; // [R7]
    end else if (sts_wr && !i_wb_dat[FUR_ST_RDF] && arm_reg[1]) begin
      rdf_reg <= 1'b0; // [R7]
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (clr) begin
      dr_reg <= 1'b0;
      brk_reg <= 1'b0;
    end else begin
      if (tmo_evt && !at_trig && cnt_reg != 5'h00) begin
        dr_reg <= 1'b1; // [R10]
      end else if (sts_wr && !i_wb_dat[FUR_ST_DR] && arm_reg[0]) begin
        dr_reg <= 1'b0; // [R11]
      end
      if (brk_evt) begin
        brk_reg <= 1'b1; // [R17]
      end else if (sts_wr && !i_wb_dat[FUR_ST_BRK] && arm_reg[2]) begin
        brk_reg <= 1'b0;
      end
    end
  end

  // Read of 1 arms the later write-0 clear
  always_ff @(posedge i_clk_sys) begin
    if (clr || sts_wr) begin
      arm_reg <= 3'b000; // [R11]
    end else if (sts_rd) begin
      arm_reg <= arm_reg | {brk_reg, rdf_reg, dr_reg}; // [R11]
    end
  end

  // ==========================================================
  // Interrupts
  always_ff @(posedge i_clk_sys) begin
    if (clr) begin
      irq_sts_reg <= 4'h0;
      o_irq <= 1'b0;
    end else begin
      irq_sts_reg <= (rd && hit(i_wb_adr, FUR_OFF_IRQ_STS) ? 4'h0 : irq_sts_reg)
                     | {push & (frame_reg.ferr | frame_reg.perr), brk_evt,
                        tmo_evt & ~at_trig & (cnt_reg != 5'h00), at_trig & push_q_reg};
      o_irq <= |(irq_sts_reg & mask_reg);
    end
  end

  // ==========================================================
  // Read multiplexer
  assign pcnt_show = (pcnt_reg > 5'h0f) ? 4'hf : pcnt_reg[3:0];
  assign fcnt_show = (fcnt_reg > 5'h0f) ? 4'hf : fcnt_reg[3:0];
  assign status = {pcnt_show, fcnt_show, 3'b000, brk_reg, fer_reg, per_reg, rdf_reg, dr_reg}; // [R12] [R13]

  always_comb begin
    if (hit(i_wb_adr, FUR_OFF_MODE)) begin
      rdata = {24'h000000, mode_reg};
    end else if (hit(i_wb_adr, FUR_OFF_BRR)) begin
      rdata = {24'h000000, brr_reg}; // [R14]
    end else if (hit(i_wb_adr, FUR_OFF_STATUS)) begin
      rdata = {16'h0000, status};
    end else if (hit(i_wb_adr, FUR_OFF_FCR)) begin
      rdata = {24'h000000, fcr_reg};
    end else if (hit(i_wb_adr, FUR_OFF_RXDATA)) begin
      rdata = {24'h000000, head.data}; // [R8]
    end else if (hit(i_wb_adr, FUR_OFF_FCOUNT)) begin
      rdata = {24'h000000, 3'b000, cnt_reg}; // [R9]
    end else if (hit(i_wb_adr, FUR_OFF_IRQ_STS)) begin
      rdata = {28'h0000000, irq_sts_reg};
    end else if (hit(i_wb_adr, FUR_OFF_IRQ_MASK)) begin
      rdata = {28'h0000000, mask_reg};
    end else begin
      rdata = 32'h0000_0000;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (clr);

  sequence s_ack_pulse;
    o_wb_ack ##1 !o_wb_ack;
  endsequence

  property p_ack_one;
    take |=> s_ack_pulse;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("Ack not a single cycle after request");

  property p_no_store_blocked;
    block_reg |-> !push;
  endproperty
  a_no_store_blocked: assert property (p_no_store_blocked) else $error("Byte stored during break"); // [R1]

  property p_fer_follows_read;
    pop |=> fer_reg == $past(head.ferr);
  endproperty
  a_fer_follows_read: assert property (p_fer_follows_read) else $error("Framing flag wrong after read"); // [R2]

  property p_per_follows_read;
    pop |=> per_reg == $past(head.perr);
  endproperty
  a_per_follows_read: assert property (p_per_follows_read) else $error("Parity flag wrong after read"); // [R4]

  property p_rdf_below;
    !at_trig |=> !rdf_reg || at_trig;
  endproperty
  a_rdf_below: assert property (p_rdf_below) else $error("Fill flag set below trigger"); // [R7]

  property p_cnt_max;
    cnt_reg <= DEPTH[FUR_CNT_W-1:0];
  endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("FIFO count above depth"); // [R8]

  property p_dr_needs_arm;
    (dr_reg && !arm_reg[0]) |=> dr_reg;
  endproperty
  a_dr_needs_arm: assert property (p_dr_needs_arm) else $error("Ready flag cleared without read"); // [R11]

  property p_brr_reset;
    @(posedge i_clk_sys) disable iff (1'b0)
    i_sys_rst |=> brr_reg == FUR_BRR_RST;
  endproperty
  a_brr_reset: assert property (p_brr_reset) else $error("Bit-rate register not all ones after reset"); // [R14]
endmodule
`default_nettype wire

// ---- sim/fur_tx_model.sv ----
// Remote serial transmitter model driving the receive line
`timescale 1ns/100ps
`default_nettype none
module fur_tx_model (
  // Clock
  input wire logic i_clk_sys,
  // Serial line, idle at mark
  output logic o_line
);
  initial o_line = 1'b1;
  // ==========================================================
  // Hold one line level for n clocks
  task automatic put(input logic v, input int n);
    o_line <= v;
    repeat (n) @(posedge i_clk_sys);
  endtask
  // ==========================================================
  // One character: start, 8 bits LSB first, optional parity, stop
  task automatic send(input logic [7:0] b, input int bc, input logic pe, input logic odd,
                      input logic bad_par, input logic bad_stop);
    put(1'b0, bc);
    for (int i = 0; i < 8; i++) begin
      put(b[i], bc);
    end
    if (pe) begin
      put(^b ^ odd ^ bad_par, bc);
    end
    put(~bad_stop, bc);
    o_line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the receive status and baud block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import fur_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic stby = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  wire logic [31:0] q;
  wire logic ack;
  wire logic irq;
  wire logic line;
  int n_errors = 0;
  int n_checks = 0;
  int bc = 32;
  logic par_odd = 1'b0;
  always #25 clk = ~clk;
  fur_uart_rx #(.DEPTH(FUR_FIFO_DEPTH)) dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_standby(stby), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(q), .o_wb_ack(ack),
    .i_rxd(line), .o_irq(irq));
  fur_tx_model m (.i_clk_sys(clk), .o_line(line));
  // ==========================================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rdat = q;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rdat & mk);
  endtask
  task automatic tx(input logic [7:0] b, input logic pe, input logic bp, input logic bs);
    m.send(b, bc, pe, par_odd, bp, bs);
    repeat (10) @(posedge clk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rd(FUR_OFF_BRR, 32'hff, 32'hff, "brr_rst");
    rd(FUR_OFF_STATUS, 32'hff1f, 32'h0, "status_rst");
    wr(FUR_OFF_BRR, 32'h5a);
    rd(FUR_OFF_BRR, 32'hffffffff, 32'h5a, "brr_rw");
    sel <= 4'he;
    wr(FUR_OFF_BRR, 32'h33);
    sel <= 4'hf;
    rd(FUR_OFF_BRR, 32'hff, 32'h5a, "brr_sel");
    rd(8'h40, 32'hffffffff, 32'h0, "unmapped");
    wr(FUR_OFF_BRR, 32'h0);
    $display("Test regs done");
  endtask
  task automatic t_fill;
    wr(FUR_OFF_FCR, 32'h40);
    for (int i = 0; i < 4; i++) begin
      rd(FUR_OFF_STATUS, 32'h2, 32'h0, "fill_below");
      tx(8'h11 + 8'(i), 1'b0, 1'b0, 1'b0);
    end
    rd(FUR_OFF_STATUS, 32'h2, 32'h2, "fill_at");
    rd(FUR_OFF_FCOUNT, 32'hff, 32'h4, "count");
    rd(FUR_OFF_RXDATA, 32'hff, 32'h11, "data0");
    rd(FUR_OFF_STATUS, 32'h2, 32'h0, "fill_pop");
    tx(8'h20, 1'b0, 1'b0, 1'b0);
    rd(FUR_OFF_STATUS, 32'h2, 32'h2, "fill_again");
    wr(FUR_OFF_STATUS, 32'h0);
    rd(FUR_OFF_STATUS, 32'h2, 32'h0, "fill_wr0");
    for (int i = 0; i < 4; i++) begin
      rd(FUR_OFF_RXDATA, 32'hff, (i == 3) ? 32'h20 : 32'h12 + 32'(i), "drain");
    end
    rd(FUR_OFF_FCOUNT, 32'hff, 32'h0, "empty");
    $display("Test fill done");
  endtask
  task automatic t_err;
    // Even parity first, then odd parity
    for (int k = 0; k < 2; k++) begin
      par_odd = (k == 1);
      wr(FUR_OFF_MODE, 32'h20 | (32'(k) << 4));
      tx(8'h5a, 1'b1, 1'b1, 1'b0);
      tx(8'h3c, 1'b1, 1'b0, 1'b1);
      tx(8'h01, 1'b1, 1'b0, 1'b0);
      rd(FUR_OFF_STATUS, 32'hff0c, 32'h1100, "err_counts");
      rd(FUR_OFF_RXDATA, 32'hff, 32'h5a, "perr_byte");
      rd(FUR_OFF_STATUS, 32'hff0c, 32'h0104, "per_flag");
      rd(FUR_OFF_RXDATA, 32'hff, 32'h3c, "ferr_byte");
      rd(FUR_OFF_STATUS, 32'hff0c, 32'h0008, "fer_flag");
      rd(FUR_OFF_RXDATA, 32'hff, 32'h01, "clean_byte");
      rd(FUR_OFF_STATUS, 32'hff0c, 32'h0, "flags_clear");
    end
    par_odd = 1'b0;
    wr(FUR_OFF_MODE, 32'h0);
    $display("Test errors done");
  endtask
  task automatic t_ready;
    wr(FUR_OFF_FCR, 32'h80);
    bus(1'b0, FUR_OFF_STATUS, 32'h0);
    wr(FUR_OFF_STATUS, 32'h0);
    bus(1'b0, FUR_OFF_IRQ_STS, 32'h0);
    wr(FUR_OFF_IRQ_MASK, 32'h2);
    tx(8'h77, 1'b0, 1'b0, 1'b0);
    repeat (400) @(posedge clk);
    chk("irq_early", 32'h0, {31'h0, irq});
    repeat (100) @(posedge clk);
    chk("irq_ready", 32'h1, {31'h0, irq});
    wr(FUR_OFF_STATUS, 32'h0);
    rd(FUR_OFF_STATUS, 32'h1, 32'h1, "dr_kept");
    wr(FUR_OFF_STATUS, 32'h0);
    rd(FUR_OFF_STATUS, 32'h1, 32'h0, "dr_clear");
    rd(FUR_OFF_IRQ_STS, 32'h2, 32'h2, "irq_sts");
    rd(FUR_OFF_IRQ_STS, 32'h2, 32'h0, "irq_sts_clr");
    repeat (2) @(posedge clk);
    chk("irq_low", 32'h0, {31'h0, irq});
    rd(FUR_OFF_RXDATA, 32'hff, 32'h77, "ready_byte");
    $display("Test ready done");
  endtask
  task automatic t_brk;
    wr(FUR_OFF_FCR, 32'h00);
    m.put(1'b0, 40 * bc);
    m.put(1'b1, 25 * bc);
    tx(8'h33, 1'b0, 1'b0, 1'b0);
    rd(FUR_OFF_FCOUNT, 32'hff, 32'h2, "brk_count");
    rd(FUR_OFF_STATUS, 32'h0f12, 32'h0112, "brk_flag");
    rd(FUR_OFF_IRQ_STS, 32'hc, 32'hc, "irq_brk");
    rd(FUR_OFF_RXDATA, 32'hff, 32'h0, "brk_byte");
    rd(FUR_OFF_STATUS, 32'h8, 32'h8, "brk_fer");
    rd(FUR_OFF_RXDATA, 32'hff, 32'h33, "after_brk");
    $display("Test break done");
  endtask
  task automatic t_baud;
    for (int c = 0; c < 5; c++) begin
      wr(FUR_OFF_MODE, 32'(c % 4));
      wr(FUR_OFF_BRR, 32'(c / 4));
      bc = 32 * (4 ** (c % 4)) * (c / 4 + 1);
      tx(8'ha5 ^ 8'(c), 1'b0, 1'b0, 1'b0);
      rd(FUR_OFF_RXDATA, 32'hff, 32'ha5 ^ 32'(c), "baud_byte");
    end
    wr(FUR_OFF_BRR, 32'h0);
    wr(FUR_OFF_MODE, 32'h0);
    bc = 32;
    $display("Test baud done");
  endtask
  task automatic t_full;
    wr(FUR_OFF_FCR, 32'hc0);
    for (int i = 0; i < 17; i++) begin
      if (i == 13) begin
        rd(FUR_OFF_STATUS, 32'h2, 32'h0, "fill_13");
      end
      tx(8'h40 + 8'(i), 1'b0, 1'b0, 1'b0);
    end
    rd(FUR_OFF_STATUS, 32'h2, 32'h2, "fill_14");
    rd(FUR_OFF_FCOUNT, 32'hff, 32'h10, "full_count");
    rd(FUR_OFF_RXDATA, 32'hff, 32'h40, "full_first");
    @(posedge clk);
    stby <= 1'b1;
    @(posedge clk);
    stby <= 1'b0;
    rd(FUR_OFF_FCOUNT, 32'hff, 32'h0, "stby_count");
    rd(FUR_OFF_BRR, 32'hff, 32'hff, "stby_brr");
    rd(FUR_OFF_STATUS, 32'hff1f, 32'h0, "stby_status");
    $display("Test full done");
  endtask
  // ==========================================================
  // Verdict and run control
  task automatic final_report;
    $display("Checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    $display("FAIL watchdog expected finish seen hang");
    final_report;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_fill;
    t_err;
    t_ready;
    t_brk;
    t_baud;
    t_full;
    final_report;
  end
endmodule
`default_nettype wire
